// File: rtl/pwp_cfg.svh
`ifndef PWP_CFG_SVH
`define PWP_CFG_SVH

// register byte offsets inside the bank
`define PWP_OFS_CLEAR      8'h00
`define PWP_OFS_SET        8'h04
// protection field: bit 1 up to bit 6 of the data word
`define PWP_FIELD_LSB      1
`define PWP_FIELD_MSB      6
`define PWP_NUM_PERIPH     6
// reset value of the protection vector: nothing protected
`define PWP_PROT_RESET     6'h00
// answer cycles from the taken access phase to ready
`define PWP_ANSWER_CYCLES  1

`endif

// File: rtl/pwp_pkg.sv
package pwp_pkg;

    // peripheral bus request as seen by the bank
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } pwp_bus_req_t;

    // write attempt on one guarded peripheral
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       debug;
        logic [2:0] idx;
    } pwp_guard_req_t;

    // which register an address selects
    typedef enum logic [1:0] {
        PWP_SEL_CLEAR = 2'b00,
        PWP_SEL_SET   = 2'b01,
        PWP_SEL_NONE  = 2'b10
    } pwp_sel_t;

endpackage : pwp_pkg

// File: rtl/pwp_bits.sv
`timescale 1ns/1ns
`include "pwp_cfg.svh"

// shared protection vector behind both set and clear views
module pwp_bits #(
    parameter int N = `PWP_NUM_PERIPH
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] set_mask_i,
    input  wire logic [N-1:0] clr_mask_i,
    output logic      [N-1:0] prot_o
);
    import pwp_pkg::*;

    // one vector, so both registers always read alike
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prot_o <= N'(`PWP_PROT_RESET);
        end else begin
            // zeros in both masks leave the bit alone
            prot_o <= (prot_o & ~clr_mask_i) | set_mask_i;
        end
    end

endmodule : pwp_bits

// File: rtl/pwp_top.sv
`timescale 1ns/1ns
`include "pwp_cfg.svh"

// Notes on behaviour
// R1: writing zero leaves protection bit unchanged
// R2: clear register one removes peripheral protection
// R3: bit reads 1 protected, 0 writable
// R4: clear register at 0x00, resets unprotected
// R5: set register at 0x04, same layout
// R6: bits 1..6 hold the six peripherals
// R7: set one protects; both views share vector
// R8: protected peripheral write refused with error
// R9: double protect or unprotect gives error
// R10: debugger writes bypass write protection
// R11: unused bits read zero, ignore writes
module pwp_top #(
    parameter int N = `PWP_NUM_PERIPH
) (
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_i,
    input  wire pwp_pkg::pwp_bus_req_t   bus_i,
    output logic                         pready_o,
    output logic                         pslverr_o,
    output logic [31:0]                  prdata_o,
    input  wire pwp_pkg::pwp_guard_req_t guard_i,
    output logic                         guard_grant_o,
    output logic                         guard_err_o
);
    import pwp_pkg::*;

    logic           pready_reg;   // answer strobe
    logic           pslverr_reg;  // error with the answer
    logic [31:0]    prdata_reg;   // read data with the answer
    logic           grant_reg;    // guarded write let through
    logic           gerr_reg;     // guarded write refused
    logic [N-1:0]   prot;         // protection vector
    logic           take;         // access phase taken this cycle
    pwp_sel_t       sel;          // decoded register
    logic [N-1:0]   wmask;        // written ones of the field
    logic [N-1:0]   set_mask;
    logic [N-1:0]   clr_mask;
    logic           dbl_err;      // double protect or unprotect
    logic           prot_hit;     // guarded peripheral protected

    // address decode, low two bits ignored since each register is a word
    function automatic pwp_sel_t decode(input logic [7:0] a);
        // R4 clear register word
        if (a[7:2] == 6'(`PWP_OFS_CLEAR >> 2)) begin
            return PWP_SEL_CLEAR;
        // R5 set register word
        end else if (a[7:2] == 6'(`PWP_OFS_SET >> 2)) begin
            return PWP_SEL_SET;
        end else begin
            return PWP_SEL_NONE;
        end
    endfunction : decode

    // take the access phase once; ready drops the next cycle
    assign take = bus_i.psel & bus_i.penable & ~pready_reg;
    assign sel  = decode(bus_i.paddr);

    // R11 unused bits ignored
    // R6 field at bits 1..6, only lane 0 carries it
    assign wmask = bus_i.pwdata[`PWP_FIELD_MSB:`PWP_FIELD_LSB] & {N{bus_i.pstrb[0]}};

    // R2 clear ones drop protection
    assign clr_mask = (take && bus_i.pwrite && sel == PWP_SEL_CLEAR) ? wmask : '0;
    // R7 set ones raise protection
    assign set_mask = (take && bus_i.pwrite && sel == PWP_SEL_SET) ? wmask : '0;

    // R9 double protect or unprotect check
    assign dbl_err = ((set_mask & prot) != '0) || ((clr_mask & ~prot) != '0);

    // R1 zeros leave vector alone
    pwp_bits #(
        .N (N)
    ) u_bits (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .set_mask_i (set_mask),
        .clr_mask_i (clr_mask),
        .prot_o     (prot)
    );

    // answer strobe: one wait state, then one cycle of ready
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= take;
        end
    end

    // error answer: unmapped address or double operation
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= take && (sel == PWP_SEL_NONE || dbl_err);
        end
    end

    // read data: both registers show the same vector
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_reg <= 32'h0000_0000;
        end else if (take && !bus_i.pwrite && sel != PWP_SEL_NONE) begin
            // R3 one means protected
            prdata_reg <= {{(31 - `PWP_FIELD_MSB){1'b0}}, prot, 1'b0};
        end else begin
            // cleared so stale data never leaks on writes or holes
            prdata_reg <= 32'h0000_0000;
        end
    end

    // index 1..6 maps to vector bit 0..5; others are never protected
    assign prot_hit = (guard_i.idx >= 3'h1) && (guard_i.idx <= 3'h6) && prot[guard_i.idx - 3'h1];

    // guard answer one cycle after the attempt
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            grant_reg <= 1'b0;
            gerr_reg  <= 1'b0;
        end else begin
            // R8 protected write refused
            // R10 debugger bypasses protection
            grant_reg <= guard_i.valid && !(guard_i.write && prot_hit && !guard_i.debug);
            gerr_reg  <= guard_i.valid && guard_i.write && prot_hit && !guard_i.debug;
        end
    end

    assign pready_o      = pready_reg;
    assign pslverr_o     = pslverr_reg;
    assign prdata_o      = prdata_reg;
    assign guard_grant_o = grant_reg;
    assign guard_err_o   = gerr_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    sequence s_write_taken;
        take && bus_i.pwrite;
    endsequence

    sequence s_ready_err;
        pready_o && pslverr_o;
    endsequence

    property p_clear_drops;
        s_write_taken and (sel == PWP_SEL_CLEAR) |=> (prot & $past(clr_mask)) == '0;
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("clear did not drop protection"); // R2

    property p_set_raises;
        s_write_taken and (sel == PWP_SEL_SET) |=> (prot & $past(set_mask)) == $past(set_mask);
    endproperty
    a_set_raises: assert property (p_set_raises) else $error("set did not raise protection"); // R7

    property p_zero_keeps;
        take && bus_i.pwrite && wmask == '0 |=> prot == $past(prot);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed protection"); // R1

    property p_read_shows;
        take && !bus_i.pwrite && sel != PWP_SEL_NONE |=> prdata_o[N:1] == $past(prot) && pready_o;
    endproperty
    a_read_shows: assert property (p_read_shows) else $error("read data differs from vector"); // R3

    property p_unused_zero;
        pready_o |-> prdata_o[31:N+1] == '0 && !prdata_o[0];
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero"); // R11

    property p_decode_set;
        take && bus_i.paddr == `PWP_OFS_SET |-> sel == PWP_SEL_SET;
    endproperty
    a_decode_set: assert property (p_decode_set) else $error("set offset not decoded"); // R5

    property p_decode_clear;
        take && bus_i.paddr == `PWP_OFS_CLEAR |-> sel == PWP_SEL_CLEAR;
    endproperty
    a_decode_clear: assert property (p_decode_clear) else $error("clear offset not decoded"); // R4

    property p_double_err;
        s_write_taken and ((set_mask & prot) != '0) |=> s_ready_err ##1 !pready_o;
    endproperty
    a_double_err: assert property (p_double_err) else $error("double protect not flagged"); // R9

    property p_guard_block;
        guard_i.valid && guard_i.write && !guard_i.debug && prot_hit |=> guard_err_o && !guard_grant_o;
    endproperty
    a_guard_block: assert property (p_guard_block) else $error("protected write let through"); // R8

    property p_debug_pass;
        guard_i.valid && guard_i.debug |=> guard_grant_o && !guard_err_o;
    endproperty
    a_debug_pass: assert property (p_debug_pass) else $error("debugger write refused"); // R10

    // clearing an unprotected peripheral is flagged like a double protect
    property p_double_clear;
        s_write_taken and ((clr_mask & ~prot) != '0) |=> s_ready_err;
    endproperty
    a_double_clear: assert property (p_double_clear) else $error("double unprotect not flagged"); // R9

    // a set write only adds protection, it never drops a bit
    property p_set_keeps;
        s_write_taken and (sel == PWP_SEL_SET) |=> (prot & $past(prot)) == $past(prot);
    endproperty
    a_set_keeps: assert property (p_set_keeps) else $error("set write dropped protection"); // R7

    // hole in the map answers with an error and leaves the vector alone
    property p_unmapped_err;
        take && sel == PWP_SEL_NONE |=> s_ready_err and (prot == $past(prot));
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused"); // R4

    // every guard attempt gets exactly one answer
    property p_guard_one;
        guard_i.valid |=> guard_grant_o != guard_err_o;
    endproperty
    a_guard_one: assert property (p_guard_one) else $error("guard answer not unique"); // R8

endmodule : pwp_top

// File: tb/pwp_master.sv
`timescale 1ns/1ns
// bus master model: one transfer at a time, all changes on falling edges
module pwp_master (
    input  wire logic             clk_sys_i,
    input  wire logic             pready_i,
    input  wire logic             pslverr_i,
    input  wire logic [31:0]      prdata_i,
    output pwp_pkg::pwp_bus_req_t bus_o
);
    import pwp_pkg::*;

    // idle bus until the first transfer
    initial begin
        bus_o = '0;
    end

    // setup, access, hold until ready is seen, release with strobes cleared and other lines inverted
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic e);
        int n;
        n = 0;
        @(negedge clk_sys_i);
        bus_o <= '{1'b1, 1'b0, w, a, d, s};
        @(negedge clk_sys_i);
        bus_o.penable <= 1'b1;
        @(negedge clk_sys_i);
        // bounded wait so a dead slave cannot hang the run
        while (pready_i !== 1'b1 && n < 8) begin
            @(negedge clk_sys_i);
            n++;
        end
        rd = (n < 8) ? prdata_i : 'x;
        e  = (n < 8) ? pslverr_i : 1'bx;
        // released write, address and data lines show the inverse, strobes go to zero, never a stale copy
        @(negedge clk_sys_i);
        bus_o <= '{1'b0, 1'b0, ~w, ~a, ~d, 4'h0};
    endtask : xfer
endmodule : pwp_master

// File: tb/tb.sv
`timescale 1ns/1ns
module tb;
    import pwp_pkg::*;
    // one bus transfer and what it should give
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] r;
        logic        e;
    } pwp_row_t;

    logic           clk_sys;
    logic           rst;
    pwp_bus_req_t   bus;
    pwp_guard_req_t guard;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic           grant;
    logic           gerr;
    logic [31:0]    rd;
    logic           e;
    int             n_fail;
    int             n_checks;

    // reads, set/clear writes, double operations, unused bits, unmapped place
    localparam pwp_row_t rows [14] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h04, 32'hFFFFFFFF, 32'h0, 1'b0}, '{1'b0, 8'h00, 32'h0, 32'h7E, 1'b0},
        '{1'b1, 8'h04, 32'h2, 32'h0, 1'b1}, '{1'b1, 8'h00, 32'h4, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h7A, 1'b0}, '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h00, 32'h0, 32'h7A, 1'b0}, '{1'b1, 8'h00, 32'h4, 32'h0, 1'b1},
        '{1'b1, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h00, 32'h78, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h2, 1'b0}};

    pwp_top pwp_top_i (.clk_sys_i(clk_sys), .rst_i(rst), .bus_i(bus), .pready_o(pready),
        .pslverr_o(pslverr), .prdata_o(prdata), .guard_i(guard), .guard_grant_o(grant),
        .guard_err_o(gerr));
    pwp_master pwp_master_i (.clk_sys_i(clk_sys), .pready_i(pready), .pslverr_i(pslverr),
        .prdata_i(prdata), .bus_o(bus));

    // 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // single place where the run ends
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // watchdog: whole sequence needs well under 200 cycles
    initial begin
        #20000;
        n_fail++;
        test_done();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        rst = 1'b1;
        guard = '0;
        repeat (2) @(negedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            pwp_master_i.xfer(rows[i].w, rows[i].a, rows[i].d, 4'hF, rd, e);
            chk({31'h0, e}, {31'h0, rows[i].e});
            if (!rows[i].w) chk(rd, rows[i].r);
        end
        // lane 0 strobe low: a set write of every peripheral must change nothing
        pwp_master_i.xfer(1'b1, 8'h04, 32'h7E, 4'hE, rd, e);
        chk({31'h0, e}, 32'h0);
        pwp_master_i.xfer(1'b0, 8'h04, 32'h0, 4'hF, rd, e);
        chk(rd, 32'h2);
        // only peripheral 1 is protected now; guard held back to back
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            guard <= '{1'b1, 1'b1, 1'b0, 3'(i)};
            @(negedge clk_sys);
            chk({30'h0, grant, gerr}, (i == 1) ? 32'h1 : 32'h2);
        end
        guard <= '{1'b1, 1'b1, 1'b1, 3'h1};
        @(negedge clk_sys);
        chk({30'h0, grant, gerr}, 32'h2);
        guard <= '{1'b1, 1'b0, 1'b0, 3'h1};
        @(negedge clk_sys);
        chk({30'h0, grant, gerr}, 32'h2);
        // reset in mid-run drops all protection, guard attempt still standing
        rst <= 1'b1;
        @(negedge clk_sys);
        chk({27'h0, pready, pslverr, grant, gerr, |prdata}, 32'h0);
        guard <= '0;
        rst <= 1'b0;
        pwp_master_i.xfer(1'b0, 8'h04, 32'h0, 4'hF, rd, e);
        chk(rd, 32'h0);
        chk({31'h0, e}, 32'h0);
        test_done();
    end
endmodule : tb
